// ==== include/pfcc_pkg.sv ====
// package: constants, commands and carriers of the parallel flash command controller
package pfcc_pkg;
  // clock and bus timing, figures in their own units, counts derived
  localparam int CLK_NS = 10;
  localparam int T_WP_NS = 50; // write strobe low time, well above the noise filter
  localparam int WP_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_ACC_NS = 85; // read access time
  localparam int ACC_CYC = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_RST_NS = 500; // reset pin low time
  localparam int RST_CYC = (T_RST_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_SUSP_US = 15; // longest time to halt an erase
  localparam int SUSP_CYC = (T_SUSP_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int T_SETTLE_NS = 100; // time for the done line to fall
  localparam int SETTLE_CYC = (T_SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_PWRUP_MS = 10; // delay before programming after reset
  localparam int PWRUP_CYC = T_PWRUP_MS * 1000000 / CLK_NS;
  localparam int CNT_W = 12;
  localparam int PWR_W = 24;

  // register offsets (byte addresses)
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_ADDR = 8'h04;
  localparam logic [7:0] OFS_WDATA = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_RDATA = 8'h10;

  // command addresses and codes
  localparam logic [20:0] ADR_555 = 21'h000555;
  localparam logic [20:0] ADR_AAA = 21'h000AAA;
  localparam logic [20:0] ADR_BLKB = 21'h000080;
  localparam logic [15:0] D_UNLK1 = 16'h00AA;
  localparam logic [15:0] D_UNLK2 = 16'h0055;
  localparam logic [15:0] D_ERASE = 16'h0080;
  localparam logic [15:0] D_CHIP = 16'h0010;
  localparam logic [15:0] D_SECT = 16'h0030;
  localparam logic [15:0] D_LOCK = 16'h0060;
  localparam logic [15:0] D_PROG = 16'h00A0;
  localparam logic [15:0] D_SUSP = 16'h00B0;
  localparam logic [15:0] D_RESUME = 16'h0030;
  localparam logic [15:0] D_IDIN = 16'h0090;
  localparam logic [15:0] D_IDOUT = 16'h00F0;
  localparam logic [15:0] D_PROT = 16'h00C0;
  localparam logic [15:0] D_PLOCK = 16'h0000;

  typedef enum logic [3:0] {
    OP_READ = 4'h0, OP_CHIP_ERASE = 4'h1, OP_SECT_ERASE = 4'h2, OP_PROGRAM = 4'h3,
    OP_SECT_LOCK = 4'h4, OP_SUSPEND = 4'h5, OP_RESUME = 4'h6, OP_ID_ENTRY = 4'h7,
    OP_ID_EXIT3 = 4'h8, OP_ID_EXIT1 = 4'h9, OP_PROT_PROG = 4'hA, OP_PROT_LOCK = 4'hB,
    OP_BLKB_STAT = 4'hC, OP_HW_RESET = 4'hD
  } pfcc_op_t;

  // flash pins driven by the bus cycle engine
  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic [20:0] addr;
    logic [15:0] dq_o;
    logic dq_oe;
  } pfcc_pins_t;

  // one bus cycle request
  typedef struct packed {
    logic is_read;
    logic [20:0] addr;
    logic [15:0] data;
  } pfcc_step_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } pfcc_apb_req_t;

  typedef struct packed {
    logic busy;
    logic rdy_pin;
    logic prog_ok;
    logic id_mode;
    logic suspended;
    logic refused;
    logic [15:0] rdata;
  } pfcc_status_t;
endpackage

// ==== src/pfcc_bus_cycle.sv ====
// one asynchronous flash bus cycle, write or read
`timescale 1ns/1ns
module pfcc_bus_cycle (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  input wire logic i_start,
  input wire pfcc_pkg::pfcc_step_t i_step,
  input wire logic [15:0] i_dq,
  output logic o_done,
  output logic [15:0] o_rdata,
  output pfcc_pkg::pfcc_pins_t o_pins
);
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00, PH_SETUP = 2'b01, PH_STROBE = 2'b10, PH_HOLD = 2'b11
  } pfcc_ph_t;

  typedef struct packed {
    pfcc_ph_t ph;
    logic rd;
    logic [3:0] cnt;
    logic done;
    logic [15:0] rdata;
    pfcc_pkg::pfcc_pins_t pins;
  } pfcc_bc_state_t;

  pfcc_bc_state_t s;
  pfcc_bc_state_t next_s;

  // phase sequencing: chip select first, strobe second, release in reverse order
  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    case (s.ph)
      PH_IDLE: begin
        if (i_start) begin
          next_s.ph = PH_SETUP;
          next_s.rd = i_step.is_read;
          next_s.pins.ce_n = 1'b0;
          next_s.pins.addr = i_step.addr;
          next_s.pins.dq_o = i_step.data;
          next_s.pins.dq_oe = ~i_step.is_read;
        end
      end
      PH_SETUP: begin
        next_s.ph = PH_STROBE;
        if (s.rd) begin
          next_s.pins.oe_n = 1'b0;
          next_s.cnt = 4'(pfcc_pkg::ACC_CYC - 1);
        end else begin
          next_s.pins.we_n = 1'b0; // (output enable stays high)
          next_s.cnt = 4'(pfcc_pkg::WP_CYC - 1);
        end
      end
      PH_STROBE: begin
        if (s.cnt != 4'h0) begin
          next_s.cnt = s.cnt - 4'h1;
        end else begin
          next_s.ph = PH_HOLD;
          next_s.pins.oe_n = 1'b1;
          next_s.pins.we_n = 1'b1;
          if (s.rd) begin
            next_s.rdata = i_dq;
          end
        end
      end
      PH_HOLD: begin
        // data still driven while the strobe rises, so the device latches it cleanly
        next_s.ph = PH_IDLE;
        next_s.pins.ce_n = 1'b1;
        next_s.pins.dq_oe = 1'b0;
        next_s.done = 1'b1;
      end
      default: begin
        next_s.ph = PH_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      s <= '{ph: PH_IDLE, rd: 1'b0, cnt: 4'h0, done: 1'b0, rdata: 16'h0000,
             pins: '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: 21'h000000,
                     dq_o: 16'h0000, dq_oe: 1'b0}};
    end else if (i_clk_en) begin
      s <= next_s;
    end
  end

  assign o_done = s.done;
  assign o_rdata = s.rdata;
  assign o_pins = s.pins;
endmodule // pfcc_bus_cycle

// ==== src/pfcc_apb_regs.sv ====
// apb slave holding the command, address and data registers
`timescale 1ns/1ns
module pfcc_apb_regs (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  input wire pfcc_pkg::pfcc_apb_req_t i_apb,
  input wire pfcc_pkg::pfcc_status_t i_status,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic o_cmd_valid,
  output logic [3:0] o_cmd_op,
  output logic [20:0] o_addr,
  output logic [15:0] o_wdata
);
  typedef struct packed {
    logic ready;
    logic slverr;
    logic [31:0] prdata;
    logic cmd_valid;
    logic [3:0] op;
    logic [20:0] addr;
    logic [15:0] wdata;
  } pfcc_rg_state_t;

  pfcc_rg_state_t s;
  pfcc_rg_state_t next_s;
  logic mapped;

  // decode, read mux and write update
  always_comb begin
    next_s = s;
    next_s.cmd_valid = 1'b0;
    next_s.slverr = 1'b0;
    mapped = (i_apb.paddr == pfcc_pkg::OFS_CMD) || (i_apb.paddr == pfcc_pkg::OFS_ADDR) ||
             (i_apb.paddr == pfcc_pkg::OFS_WDATA) || (i_apb.paddr == pfcc_pkg::OFS_STATUS) ||
             (i_apb.paddr == pfcc_pkg::OFS_RDATA);
    // one wait state: ready rises the cycle after the access phase opens
    next_s.ready = i_apb.psel & i_apb.penable & ~s.ready;
    if (i_apb.psel & i_apb.penable & ~s.ready) begin
      next_s.slverr = ~mapped;
      next_s.prdata = 32'h00000000;
      if (!i_apb.pwrite) begin
        case (i_apb.paddr)
          pfcc_pkg::OFS_CMD: next_s.prdata = {28'h0000000, s.op};
          pfcc_pkg::OFS_ADDR: next_s.prdata = {11'h000, s.addr};
          pfcc_pkg::OFS_WDATA: next_s.prdata = {16'h0000, s.wdata};
          pfcc_pkg::OFS_STATUS: next_s.prdata = {26'h0000000, i_status.refused,
            i_status.suspended, i_status.id_mode, i_status.prog_ok, i_status.rdy_pin,
            i_status.busy};
          pfcc_pkg::OFS_RDATA: next_s.prdata = {16'h0000, i_status.rdata};
          default: next_s.prdata = 32'h00000000;
        endcase
      end
    end
    // writes take effect only at the edge where ready is seen high
    if (i_apb.psel & i_apb.penable & s.ready & i_apb.pwrite) begin
      case (i_apb.paddr)
        pfcc_pkg::OFS_CMD: begin
          next_s.op = i_apb.pwdata[3:0];
          next_s.cmd_valid = 1'b1;
        end
        pfcc_pkg::OFS_ADDR: next_s.addr = i_apb.pwdata[20:0];
        pfcc_pkg::OFS_WDATA: next_s.wdata = i_apb.pwdata[15:0];
        default: next_s.op = s.op;
      endcase
    end
  end

  // state register
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      s <= '{ready: 1'b0, slverr: 1'b0, prdata: 32'h00000000, cmd_valid: 1'b0,
             op: 4'h0, addr: 21'h000000, wdata: 16'h0000};
    end else if (i_clk_en) begin
      s <= next_s;
    end
  end

  assign o_prdata = s.prdata;
  assign o_pready = s.ready;
  assign o_pslverr = s.slverr;
  assign o_cmd_valid = s.cmd_valid;
  assign o_cmd_op = s.op;
  assign o_addr = s.addr;
  assign o_wdata = s.wdata;
endmodule // pfcc_apb_regs

// ==== src/pfcc_top.sv ====
// host controller that drives a dual-plane parallel flash through its pins
//
// Overview of operation
// - write is strobe pulse, output enable high
// - resume carries plane on top address bits
// - block B lock needs data bit 1 zero
// - protection reads sit inside id mode
// - unlock writes AA at 555, 55 at AAA
//
// Decided for this implementation: the APB slave port and the placing of the registers.
`timescale 1ns/1ns
module pfcc_top #(
  parameter int PWRUP_CYC = pfcc_pkg::PWRUP_CYC,
  parameter int SUSP_CYC = pfcc_pkg::SUSP_CYC
) (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  input wire pfcc_pkg::pfcc_apb_req_t i_apb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output pfcc_pkg::pfcc_pins_t o_flash,
  output logic o_flash_rst_n,
  input wire logic [15:0] i_dq,
  input wire logic i_rdy
);
  typedef enum logic [2:0] {
    ST_RST = 3'b000, ST_IDLE = 3'b001, ST_CYCLE = 3'b010, ST_SETTLE = 3'b011,
    ST_WAIT_RDY = 3'b100, ST_DELAY = 3'b101
  } pfcc_st_t;

  typedef struct packed {
    pfcc_st_t st;
    logic [3:0] op;
    logic [2:0] idx;
    logic [20:0] addr;
    logic [15:0] data;
    logic [pfcc_pkg::CNT_W-1:0] cnt;
    logic [pfcc_pkg::PWR_W-1:0] pwr;
    logic rst_n;
    logic start;
    logic id_mode;
    logic susp;
    logic refused;
    logic [15:0] rdata;
  } pfcc_main_state_t;

  pfcc_main_state_t s;
  pfcc_main_state_t next_s;
  pfcc_pkg::pfcc_status_t status;
  pfcc_pkg::pfcc_step_t step;
  logic cmd_valid;
  logic [3:0] cmd_op;
  logic [20:0] reg_addr;
  logic [15:0] reg_wdata;
  logic bc_done;
  logic [15:0] bc_rdata;
  logic is_prog;
  logic id_ok;

  // number of bus cycles of each command
  function automatic logic [2:0] step_count(input logic [3:0] op);
    case (op)
      pfcc_pkg::OP_CHIP_ERASE, pfcc_pkg::OP_SECT_ERASE, pfcc_pkg::OP_SECT_LOCK: step_count = 3'd6;
      pfcc_pkg::OP_PROGRAM, pfcc_pkg::OP_PROT_PROG, pfcc_pkg::OP_PROT_LOCK,
      pfcc_pkg::OP_BLKB_STAT: step_count = 3'd4;
      pfcc_pkg::OP_ID_ENTRY, pfcc_pkg::OP_ID_EXIT3: step_count = 3'd3;
      default: step_count = 3'd1;
    endcase
  endfunction

  // address and data of bus cycle idx of a command; upper data byte zero except in the data word of a program or protection program
  function automatic pfcc_pkg::pfcc_step_t step_of(input logic [3:0] op, input logic [2:0] idx,
                                                    input logic [20:0] a, input logic [15:0] d);
    pfcc_pkg::pfcc_step_t r;
    r.is_read = 1'b0;
    r.addr = pfcc_pkg::ADR_555;
    r.data = pfcc_pkg::D_UNLK1;
    if (idx == 3'd1 || idx == 3'd4) begin
      r.addr = pfcc_pkg::ADR_AAA;
      r.data = pfcc_pkg::D_UNLK2;
    end
    case (op)
      pfcc_pkg::OP_READ: begin
        r.is_read = 1'b1;
        r.addr = a;
      end
      pfcc_pkg::OP_CHIP_ERASE, pfcc_pkg::OP_SECT_ERASE, pfcc_pkg::OP_SECT_LOCK: begin
        if (idx == 3'd2) r.data = pfcc_pkg::D_ERASE;
        if (idx == 3'd5) begin
          r.addr = (op == pfcc_pkg::OP_CHIP_ERASE) ? pfcc_pkg::ADR_555 : a;
          r.data = (op == pfcc_pkg::OP_CHIP_ERASE) ? pfcc_pkg::D_CHIP :
                   (op == pfcc_pkg::OP_SECT_ERASE) ? pfcc_pkg::D_SECT : pfcc_pkg::D_LOCK;
        end
      end
      pfcc_pkg::OP_PROGRAM, pfcc_pkg::OP_PROT_PROG: begin
        if (idx == 3'd2) begin
          r.data = (op == pfcc_pkg::OP_PROGRAM) ? pfcc_pkg::D_PROG : pfcc_pkg::D_PROT;
        end
        if (idx == 3'd3) begin
          r.addr = a;
          r.data = d;
        end
      end
      pfcc_pkg::OP_PROT_LOCK: begin
        if (idx == 3'd2) r.data = pfcc_pkg::D_PROT;
        if (idx == 3'd3) begin
          r.addr = pfcc_pkg::ADR_BLKB;
          r.data = pfcc_pkg::D_PLOCK;
        end
      end
      pfcc_pkg::OP_BLKB_STAT: begin
        if (idx == 3'd2) r.data = pfcc_pkg::D_IDIN;
        if (idx == 3'd3) begin
          r.is_read = 1'b1;
          r.addr = pfcc_pkg::ADR_BLKB;
        end
      end
      pfcc_pkg::OP_ID_ENTRY: if (idx == 3'd2) r.data = pfcc_pkg::D_IDIN;
      pfcc_pkg::OP_ID_EXIT3: if (idx == 3'd2) r.data = pfcc_pkg::D_IDOUT;
      pfcc_pkg::OP_ID_EXIT1: r.data = pfcc_pkg::D_IDOUT;
      pfcc_pkg::OP_SUSPEND: r.data = pfcc_pkg::D_SUSP;
      pfcc_pkg::OP_RESUME: begin
        r.addr = {a[20:19], 19'h00000};
        r.data = pfcc_pkg::D_RESUME;
      end
      default: r.data = pfcc_pkg::D_UNLK1;
    endcase
    return r;
  endfunction

  pfcc_apb_regs u_regs (
    .i_mclk(i_mclk),
    .i_sys_rst(i_sys_rst),
    .i_clk_en(i_clk_en),
    .i_apb(i_apb),
    .i_status(status),
    .o_prdata(o_prdata),
    .o_pready(o_pready),
    .o_pslverr(o_pslverr),
    .o_cmd_valid(cmd_valid),
    .o_cmd_op(cmd_op),
    .o_addr(reg_addr),
    .o_wdata(reg_wdata)
  );

  pfcc_bus_cycle u_cycle (
    .i_mclk(i_mclk),
    .i_sys_rst(i_sys_rst),
    .i_clk_en(i_clk_en),
    .i_start(s.start),
    .i_step(step),
    .i_dq(i_dq),
    .o_done(bc_done),
    .o_rdata(bc_rdata),
    .o_pins(o_flash)
  );

  // status seen by software
  always_comb begin
    status.busy = (s.st != ST_IDLE);
    status.rdy_pin = i_rdy;
    status.prog_ok = (s.pwr == '0) && (s.st != ST_RST);
    status.id_mode = s.id_mode;
    status.suspended = s.susp;
    status.refused = s.refused;
    status.rdata = s.rdata;
  end

  // step of the current command, held stable for the bus engine
  assign step = step_of(s.op, s.idx, s.addr, s.data);

  // commands that alter the array are refused until the power-up delay has run out
  assign is_prog = is_prog_op(cmd_op);
  // inside id mode only reads, exits, block B status and a hard reset make sense
  assign id_ok = ~s.id_mode || (cmd_op == pfcc_pkg::OP_READ) ||
                 (cmd_op == pfcc_pkg::OP_ID_EXIT3) || (cmd_op == pfcc_pkg::OP_ID_EXIT1) ||
                 (cmd_op == pfcc_pkg::OP_HW_RESET) || (cmd_op == pfcc_pkg::OP_BLKB_STAT);

  // command sequencer
  always_comb begin
    next_s = s;
    next_s.start = 1'b0;
    if (s.pwr != '0) begin
      next_s.pwr = s.pwr - 1'b1;
    end
    case (s.st)
      ST_RST: begin
        // device aborts and floats while its reset pin is low
        if (s.cnt != '0) begin
          next_s.cnt = s.cnt - 1'b1;
        end else begin
          next_s.rst_n = 1'b1;
          next_s.pwr = pfcc_pkg::PWR_W'(PWRUP_CYC);
          next_s.id_mode = 1'b0;
          next_s.susp = 1'b0;
          next_s.st = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (cmd_valid) begin
          if (!id_ok || (is_prog && s.pwr != '0) || cmd_op > pfcc_pkg::OP_HW_RESET) begin
            next_s.refused = 1'b1;
          end else if (cmd_op == pfcc_pkg::OP_HW_RESET) begin
            next_s.refused = 1'b0;
            next_s.rst_n = 1'b0;
            next_s.cnt = pfcc_pkg::CNT_W'(pfcc_pkg::RST_CYC - 1);
            next_s.st = ST_RST;
          end else begin
            next_s.refused = 1'b0;
            next_s.op = cmd_op;
            next_s.addr = reg_addr;
            next_s.data = reg_wdata;
            next_s.idx = 3'd0;
            next_s.start = 1'b1;
            next_s.st = ST_CYCLE;
          end
        end
      end
      ST_CYCLE: begin
        if (bc_done) begin
          if (step.is_read) begin
            next_s.rdata = bc_rdata;
          end
          if (s.idx != step_count(s.op) - 3'd1) begin
            next_s.idx = s.idx + 3'd1;
            next_s.start = 1'b1;
          end else begin
            next_s.st = ST_IDLE;
            case (s.op)
              pfcc_pkg::OP_ID_ENTRY, pfcc_pkg::OP_BLKB_STAT: next_s.id_mode = 1'b1;
              pfcc_pkg::OP_ID_EXIT3, pfcc_pkg::OP_ID_EXIT1: next_s.id_mode = 1'b0;
              pfcc_pkg::OP_RESUME: next_s.susp = 1'b0;
              pfcc_pkg::OP_SUSPEND: begin
                // give the device its full halt time before the next access
                next_s.susp = 1'b1;
                next_s.cnt = pfcc_pkg::CNT_W'(SUSP_CYC - 1);
                next_s.st = ST_DELAY;
              end
              default: begin
                if (is_prog_op(s.op)) begin
                  next_s.cnt = pfcc_pkg::CNT_W'(pfcc_pkg::SETTLE_CYC - 1);
                  next_s.st = ST_SETTLE;
                end
              end
            endcase
          end
        end
      end
      ST_SETTLE: begin
        // the done line may take a moment to fall after the last strobe
        if (s.cnt != '0) begin
          next_s.cnt = s.cnt - 1'b1;
        end else begin
          next_s.st = ST_WAIT_RDY;
        end
      end
      ST_WAIT_RDY: begin
        // no timeout here: a stuck line is visible as busy in status
        if (i_rdy) begin
          next_s.st = ST_IDLE;
        end
      end
      ST_DELAY: begin
        if (s.cnt != '0) begin
          next_s.cnt = s.cnt - 1'b1;
        end else begin
          next_s.st = ST_IDLE;
        end
      end
      default: begin
        next_s.st = ST_IDLE;
      end
    endcase
  end

  function automatic logic is_prog_op(input logic [3:0] op);
    is_prog_op = (op == pfcc_pkg::OP_PROGRAM) || (op == pfcc_pkg::OP_CHIP_ERASE) ||
                 (op == pfcc_pkg::OP_SECT_ERASE) || (op == pfcc_pkg::OP_PROT_PROG) ||
                 (op == pfcc_pkg::OP_PROT_LOCK) || (op == pfcc_pkg::OP_SECT_LOCK);
  endfunction

  // state register; the flash sees its reset pin low first after system reset
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      s <= '{st: ST_RST, op: 4'h0, idx: 3'h0, addr: 21'h000000, data: 16'h0000,
             cnt: pfcc_pkg::CNT_W'(pfcc_pkg::RST_CYC - 1), pwr: '0, rst_n: 1'b0,
             start: 1'b0, id_mode: 1'b0, susp: 1'b0, refused: 1'b0, rdata: 16'h0000};
    end else if (i_clk_en) begin
      s <= next_s;
    end
  end

  assign o_flash_rst_n = s.rst_n;
endmodule // pfcc_top

// ==== verif/pfcc_top_sva.sv ====
// assertion checker for the flash controller's apb answers and flash pins
`timescale 1ns/1ns
module pfcc_top_sva #(
  parameter int PWRUP_CYC = 20,
  parameter int SUSP_CYC = 5
) (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  input wire pfcc_pkg::pfcc_apb_req_t i_apb,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire pfcc_pkg::pfcc_pins_t o_flash,
  input wire logic o_flash_rst_n,
  input wire logic [15:0] i_dq,
  input wire logic i_rdy
);
  logic [7:0] low_cnt;
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_sys_rst);
  // cycles the flash reset pin has been low, saturating so it never wraps
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst || o_flash_rst_n) begin
      low_cnt <= 8'h00;
    end else if (low_cnt != 8'hFF) begin
      low_cnt <= low_cnt + 8'h01;
    end
  end
  sequence strobe_low;
    !o_flash.we_n [*5];
  endsequence
  sequence read_low;
    !o_flash.oe_n [*8] ##1 !o_flash.oe_n;
  endsequence
  chk_pready_pulse: assert property (o_pready |=> !o_pready)
    else $error("pready held past one cycle");
  chk_one_wait: assert property (i_apb.psel && i_apb.penable && !o_pready |=> o_pready)
    else $error("access phase not answered");
  chk_slverr_map: assert property (o_pready |-> o_pslverr ==
    !($past(i_apb.paddr) inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10}))
    else $error("slave error wrong for address");
  chk_read_quiet: assert property (!o_flash.oe_n |-> !o_flash.dq_oe && o_flash.we_n)
    else $error("host drives data during a read");
  chk_write_ctl: assert property (!o_flash.we_n |-> o_flash.oe_n && !o_flash.ce_n && o_flash.dq_oe)
    else $error("write strobe with bad controls");
  chk_write_hold: assert property (!o_flash.we_n |-> $stable(o_flash.addr) && $stable(o_flash.dq_o))
    else $error("address or data moved under strobe");
  chk_ce_after_we: assert property ($rose(o_flash.we_n) |-> !o_flash.ce_n ##1 o_flash.ce_n)
    else $error("chip select not released after strobe");
  chk_strobe_width: assert property ($fell(o_flash.we_n) |-> strobe_low ##1 o_flash.we_n)
    else $error("write strobe width wrong");
  chk_read_width: assert property ($fell(o_flash.oe_n) |-> read_low ##1 o_flash.oe_n)
    else $error("read window width wrong");
  chk_reset_pulse: assert property ($rose(o_flash_rst_n) |-> low_cnt >= 8'd50)
    else $error("flash reset pulse too short");
endmodule // pfcc_top_sva
bind pfcc_top pfcc_top_sva #(.PWRUP_CYC(PWRUP_CYC), .SUSP_CYC(SUSP_CYC)) u_sva (
  .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_clk_en(i_clk_en), .i_apb(i_apb),
  .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .o_flash(o_flash),
  .o_flash_rst_n(o_flash_rst_n), .i_dq(i_dq), .i_rdy(i_rdy)
);

// ==== verif/pfcc_flash_model.sv ====
// behavioural flash device: four sectors of four words, locks, id mode
`timescale 1ns/1ns
module pfcc_flash_model (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire pfcc_pkg::pfcc_pins_t i_pins,
  output logic [15:0] o_dq,
  output logic o_rdy
);
  logic [15:0] mem [16];
  logic [3:0] lock;
  logic [2:0] step;
  logic [7:0] c5;
  logic idm, pol, plk, we_q;
  logic [20:0] la;
  logic [7:0] d;
  logic [1:0] sec;
  int busy;
  assign d = i_pins.dq_o[7:0];
  assign sec = la[13:12];
  assign o_rdy = (busy == 0);
  initial begin
    for (int i = 0; i < 16; i++) mem[i] = 16'hFFFF;
    plk = 1'b0;
    o_dq = 16'h0000;
  end
  // commands decode at the strobe's rising edge; busy refuses them all
  always @(posedge i_mclk) begin
    we_q <= i_pins.we_n;
    if (we_q && !i_pins.we_n) la <= i_pins.addr;
    if (busy > 0) busy <= busy - 1;
    if (!i_rst_n) begin
      step <= 3'd0;
      idm <= 1'b0;
      lock <= 4'h0;
      busy <= 0;
    end else if (!we_q && i_pins.we_n && busy == 0) begin
      step <= 3'd0;
      case (step)
        3'd0: if (d == 8'hAA && la[11:0] == 12'h555) step <= 3'd1; else if (d == 8'hF0) idm <= 1'b0;
        3'd1: if (d == 8'h55 && la[11:0] == 12'hAAA) step <= 3'd2;
        3'd2: begin
          c5 <= d;
          if (d == 8'h90) idm <= 1'b1;
          else if (d == 8'hF0) idm <= 1'b0;
          else step <= 3'd3;
        end
        3'd3: begin
          if (c5 == 8'hA0 && !lock[sec]) begin
            mem[{sec, la[1:0]}] <= mem[{sec, la[1:0]}] & i_pins.dq_o;
            pol <= ~i_pins.dq_o[7];
            busy <= 40;
          end
          if (c5 == 8'hC0 && la[7:0] == 8'h80 && !i_pins.dq_o[1]) plk <= 1'b1;
          if (c5 == 8'h80 && d == 8'hAA) step <= 3'd4;
        end
        3'd4: if (d == 8'h55) step <= 3'd5;
        3'd5: begin
          pol <= 1'b0;
          busy <= (d == 8'h30 && lock[sec]) ? 20 : 40;
          for (int i = 0; i < 16; i++)
            if ((d == 8'h10 || (d == 8'h30 && i[3:2] == sec)) && !lock[i[3:2]]) mem[i] <= 16'hFFFF;
          if (d == 8'h60) lock[sec] <= 1'b1;
        end
        default: ;
      endcase
    end
  end
  // a released bus shows a pattern that changes every cycle, never stale data
  always @(posedge i_mclk) begin
    if (i_pins.ce_n || i_pins.oe_n || !i_rst_n) o_dq <= ~o_dq;
    else if (busy > 0) o_dq <= {8'h00, pol, ~o_dq[6], 6'h00};
    else if (idm && i_pins.addr[7:0] == 8'h80) o_dq <= {14'h0000, ~plk, 1'b0};
    else if (idm) o_dq <= {15'h0000, i_pins.addr[7:0] == 8'h02 && lock[i_pins.addr[13:12]]};
    else o_dq <= mem[{i_pins.addr[13:12], i_pins.addr[1:0]}];
  end
endmodule // pfcc_flash_model

// ==== verif/pfcc_top_test.sv ====
// self-checking bench: apb command sequences against the flash model
`timescale 1ns/1ns
module pfcc_top_test;
  logic i_mclk, i_sys_rst, o_pready, o_pslverr, rst_n, rdy, serr;
  pfcc_pkg::pfcc_apb_req_t req;
  pfcc_pkg::pfcc_pins_t pins;
  logic [31:0] o_prdata, r;
  logic [15:0] dq;
  int err_count, compares, cyc;
  pfcc_top #(.PWRUP_CYC(20), .SUSP_CYC(5)) dut (
    .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_clk_en(1'b1), .i_apb(req),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .o_flash(pins),
    .o_flash_rst_n(rst_n), .i_dq(dq), .i_rdy(rdy)
  );
  pfcc_flash_model u_flash (.i_mclk(i_mclk), .i_rst_n(rst_n), .i_pins(pins), .o_dq(dq), .o_rdy(rdy));
  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end
  task automatic test_done();
    $display("mismatches %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // the whole run needs well under this many cycles
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_count++;
      test_done();
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  // request held until pready is sampled high, then released
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge i_mclk);
    req.penable <= 1'b1;
    do begin
      @(posedge i_mclk);
    end while (o_pready !== 1'b1);
    r = o_prdata;
    serr = o_pslverr;
    req <= '0;
    @(posedge i_mclk);
  endtask
  // launch one op and poll status until idle; r then holds the status
  task automatic op(input logic [3:0] c, input logic [20:0] a, input logic [15:0] d);
    apb(1'b1, pfcc_pkg::OFS_ADDR, {11'h000, a});
    apb(1'b1, pfcc_pkg::OFS_WDATA, {16'h0000, d});
    apb(1'b1, pfcc_pkg::OFS_CMD, {28'h0000000, c});
    do begin
      apb(1'b0, pfcc_pkg::OFS_STATUS, 32'h00000000);
    end while (r[0] !== 1'b0);
  endtask
  task automatic rdchk(input logic [20:0] a, input logic [15:0] e);
    op(4'h0, a, 16'h0000);
    apb(1'b0, pfcc_pkg::OFS_RDATA, 32'h00000000);
    chk("rdata", {16'h0000, e}, r);
  endtask
  initial begin
    i_sys_rst = 1'b1;
    req = '0;
    err_count = 0;
    compares = 0;
    cyc = 0;
    repeat (16) @(posedge i_mclk);
    i_sys_rst <= 1'b0;
    @(posedge i_mclk);
    apb(1'b0, pfcc_pkg::OFS_STATUS, 32'h00000000);
    chk("status", 32'h00000002, r & 32'h00000006);
    while (rst_n !== 1'b1) @(posedge i_mclk);
    op(4'h3, 21'h000001, 16'h1234);
    chk("refused", 32'h00000020, r & 32'h00000024);
    rdchk(21'h000001, 16'hFFFF);
    op(4'h3, 21'h000001, 16'h1234);
    chk("prog_ok", 32'h00000004, r & 32'h00000024);
    rdchk(21'h000001, 16'h1234);
    op(4'h3, 21'h000001, 16'hFF0F);
    rdchk(21'h000001, 16'h1204);
    op(4'h3, 21'h001001, 16'h5A5A);
    op(4'h4, 21'h001000, 16'h0000);
    op(4'h1, 21'h000000, 16'h0000);
    rdchk(21'h000001, 16'hFFFF);
    rdchk(21'h001001, 16'h5A5A);
    op(4'h2, 21'h001000, 16'h0000);
    rdchk(21'h001001, 16'h5A5A);
    apb(1'b0, pfcc_pkg::OFS_ADDR, 32'h00000000);
    chk("addr", 32'h00001001, r);
    op(4'h7, 21'h000000, 16'h0000);
    rdchk(21'h001002, 16'h0001);
    rdchk(21'h000002, 16'h0000);
    op(4'h3, 21'h000001, 16'h0000);
    chk("id refused", 32'h00000028, r & 32'h00000028);
    op(4'h9, 21'h000000, 16'h0000);
    chk("id exit", 32'h00000000, r & 32'h00000008);
    op(4'h7, 21'h000000, 16'h0000);
    op(4'h8, 21'h000000, 16'h0000);
    chk("id exit", 32'h00000000, r & 32'h00000028);
    op(4'hA, 21'h000085, 16'h00C3);
    op(4'hC, 21'h000000, 16'h0000);
    apb(1'b0, pfcc_pkg::OFS_RDATA, 32'h00000000);
    chk("blkb open", 32'h00000002, r & 32'h00000002);
    op(4'h9, 21'h000000, 16'h0000);
    op(4'hB, 21'h000000, 16'h0000);
    op(4'hC, 21'h000000, 16'h0000);
    apb(1'b0, pfcc_pkg::OFS_RDATA, 32'h00000000);
    chk("blkb locked", 32'h00000000, r & 32'h00000002);
    op(4'h9, 21'h000000, 16'h0000);
    op(4'h5, 21'h000000, 16'h0000);
    chk("suspended", 32'h00000010, r & 32'h00000030);
    op(4'h6, 21'h080000, 16'h0000);
    chk("resume", 32'h00000000, r & 32'h00000030);
    op(4'hD, 21'h000000, 16'h0000);
    rdchk(21'h001001, 16'h5A5A);
    op(4'h2, 21'h001000, 16'h0000);
    rdchk(21'h001001, 16'hFFFF);
    op(4'hE, 21'h000000, 16'h0000);
    chk("bad op", 32'h00000020, r & 32'h00000020);
    apb(1'b1, 8'h20, 32'hFFFFFFFF);
    chk("slverr", 32'h00000001, {31'h00000000, serr});
    apb(1'b0, 8'h20, 32'h00000000);
    chk("unmapped", 32'h00000000, r);
    test_done();
  end
endmodule // pfcc_top_test
